// file: lsfd_regs.svh
// Constants for the LED string fault and dimming controller
`ifndef LSFD_REGS_SVH
`define LSFD_REGS_SVH
`define LSFD_CLK_HZ 25000000
`define LSFD_FSW_MIN_HZ 200000
`define LSFD_FSW_MAX_HZ 1200000
// Switching period in clock cycles: longest at 200 kHz, shortest at 1.2 MHz
`define LSFD_PERIOD_MAX_CYC (`LSFD_CLK_HZ / `LSFD_FSW_MIN_HZ)
// Rounded up: a truncated count would let the rate exceed 1.2 MHz
`define LSFD_PERIOD_MIN_CYC ((`LSFD_CLK_HZ + `LSFD_FSW_MAX_HZ - 1) / `LSFD_FSW_MAX_HZ)
`define LSFD_PERIOD_W 8
`define LSFD_DIM_LOW_MS 50
`define LSFD_DIM_LOW_CYC ((`LSFD_CLK_HZ / 1000) * `LSFD_DIM_LOW_MS)
`define LSFD_NUM_STRINGS 4
`define LSFD_STRING_ALL 4'hf
`endif

// file: lsfd_pkg.sv
// Types for the LED string fault and dimming controller
package lsfd_pkg;
  typedef enum logic [2:0] {
    LSFD_OFF, LSFD_SOFT_START, LSFD_RUN, LSFD_SHUTDOWN
  } lsfd_state_t;
  // Comparator decisions made by the analog front end
  typedef struct packed {
    logic ovp_rise;     // overvoltage_sense reached 2.5 V
    logic ovp_fall;     // overvoltage_sense below 2.4 V
    logic scp_low;      // overvoltage_sense below 100 mV
    logic scp_high;     // overvoltage_sense above 150 mV
    logic therm_hot;    // die above 150 C
    logic therm_cool;   // die below 125 C
    logic current_set_resistor_short;   // current_set_resistor shorted to ground
    logic lsd_disable;  // short_detect_level above 3 V
  } lsfd_sense_t;
  typedef struct packed {
    logic [3:0] short_det; // string_sink_node above 10x short_detect_level
    logic [3:0] open_det;  // string_sink_node below 100 mV
  } lsfd_string_t;
endpackage : lsfd_pkg

// file: lsfd_switch_timer.sv
// Boost switching period timer with on-time control
`timescale 1ns/1ns
`include "lsfd_regs.svh"
module lsfd_switch_timer import lsfd_pkg::*; (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [`LSFD_PERIOD_W-1:0] period_in,
  input wire logic loop_off_in,
  output logic gate_out
);
  logic [`LSFD_PERIOD_W-1:0] count_reg;
  logic [`LSFD_PERIOD_W-1:0] count_next;
  logic [`LSFD_PERIOD_W-1:0] period_lim;
  logic wrap;
  logic gate_next;
  // Clamp keeps the rate inside 200 kHz .. 1.2 MHz
  assign period_lim = (period_in < `LSFD_PERIOD_W'(`LSFD_PERIOD_MIN_CYC)) ?
                      `LSFD_PERIOD_W'(`LSFD_PERIOD_MIN_CYC) :
                      (period_in > `LSFD_PERIOD_W'(`LSFD_PERIOD_MAX_CYC)) ?
                      `LSFD_PERIOD_W'(`LSFD_PERIOD_MAX_CYC) : period_in;
  assign wrap = (count_reg >= period_lim - `LSFD_PERIOD_W'(1));
  assign count_next = (!run_in || wrap) ? '0 : count_reg + `LSFD_PERIOD_W'(1);
  // On at each period start, off when the current loop ends the on-time
  assign gate_next = run_in && (wrap ? 1'b1 : (gate_out && !loop_off_in));
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= '0;
      gate_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      gate_out <= gate_next;
    end
  end
endmodule : lsfd_switch_timer

// file: lsfd_control.sv
// Supervisory fault, dimming and soft-start control for a four-string LED driver
`timescale 1ns/1ns
`include "lsfd_regs.svh"
module lsfd_control import lsfd_pkg::*; #(
  parameter int DIM_LOW_CYC = `LSFD_DIM_LOW_CYC
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic dim_in,
  input wire logic [`LSFD_PERIOD_W-1:0] period_in,
  input wire logic loop_off_in,
  input wire logic ss_done_in,
  input wire lsfd_sense_t sense_in,
  input wire lsfd_string_t string_in,
  output logic gate_out,
  output logic ss_run_out,
  output logic [3:0] sink_on_out,
  output logic fault_oe_out,
  output logic fault_o_out,
  output logic [2:0] state_out
);
  lsfd_state_t state_reg;
  lsfd_state_t state_next;
  logic [25:0] dim_low_reg;
  wire logic [3:0] str_off_reg;
  wire logic [3:0] str_off_next;
  wire logic [3:0] open_flags;
  logic sink_ok;
  logic clear_strings;
  logic ovp_reg;
  logic scp_reg;
  logic therm_reg;
  logic gate_raw;
  logic switch_ok;
  logic [3:0] short_hit;
  logic [3:0] open_hit;
  logic dim_timeout;
  logic all_open;
  logic hard_fault;
  logic fault_next;
  logic [3:0] sink_next;

  // Enable gating: the reset hold while disabled
  wire logic en_ok = enable_in;
  assign dim_timeout = (dim_low_reg >= 26'(DIM_LOW_CYC));
  // Short detect only with dimming high and when not masked by a high level
  assign short_hit = (dim_in && !sense_in.lsd_disable && state_reg == LSFD_RUN) ?
                     string_in.short_det : 4'h0;
  assign open_hit = (dim_in && sense_in.ovp_rise && state_reg == LSFD_RUN) ?
                    string_in.open_det : 4'h0;
  // Only strings flagged open count; a shorted string does not
  assign all_open = (open_flags == `LSFD_STRING_ALL);
  // Output short only counts after soft start
  wire logic scp_trip = scp_reg || (sense_in.scp_low && state_reg == LSFD_RUN);
  assign hard_fault = scp_trip || therm_reg || sense_in.therm_hot ||
                      sense_in.current_set_resistor_short || all_open;

  // Soft start and run are the only states that may drive the power stage
  function automatic logic state_active(input lsfd_state_t s);
    return (s == LSFD_SOFT_START) || (s == LSFD_RUN);
  endfunction : state_active

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LSFD_OFF: if (dim_in && !hard_fault) state_next = LSFD_SOFT_START;
      LSFD_SOFT_START: begin
        if (hard_fault || dim_timeout) state_next = LSFD_SHUTDOWN;
        else if (ss_done_in) state_next = LSFD_RUN;
      end
      LSFD_RUN: if (hard_fault || dim_timeout) state_next = LSFD_SHUTDOWN;
      LSFD_SHUTDOWN: begin
        // Leaving shutdown always restarts soft start
        if (!hard_fault && dim_in) state_next = LSFD_SOFT_START;
      end
    endcase
  end

  // Overvoltage hysteresis: stop at 2.5 V, resume below 2.4 V
  wire logic ovp_next = sense_in.ovp_rise ? 1'b1 : (sense_in.ovp_fall ? 1'b0 : ovp_reg);
  wire logic scp_next = (state_reg == LSFD_SOFT_START) ? 1'b0 :
                        (scp_trip && !sense_in.scp_high);
  wire logic therm_next = sense_in.therm_hot ? 1'b1 :
                          (sense_in.therm_cool ? 1'b0 : therm_reg);
  // Decided on the next state, so outputs and state_out change together
  assign sink_ok = state_active(state_next) && !hard_fault;
  // Overvoltage halts only the power switch; the string sinks keep running
  assign switch_ok = sink_ok && !ovp_next;
  // Latched string faults clear in shutdown and while enable is low
  assign clear_strings = (state_reg == LSFD_SHUTDOWN) || !en_ok;

  // One fault latch pair per string
  genvar gi;
  generate
    for (gi = 0; gi < `LSFD_NUM_STRINGS; gi++) begin : g_string
      logic off_reg;
      logic open_reg;
      wire logic off_next = clear_strings ? 1'b0 :
                            (off_reg | short_hit[gi] | open_hit[gi]);
      wire logic open_next = clear_strings ? 1'b0 : (open_reg | open_hit[gi]);
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          off_reg <= 1'b0;
          open_reg <= 1'b0;
        end else begin
          off_reg <= off_next;
          open_reg <= open_next;
        end
      end
      assign str_off_reg[gi] = off_reg;
      assign str_off_next[gi] = off_next;
      assign open_flags[gi] = open_next;
    end
  endgenerate

  assign sink_next = (dim_in && sink_ok) ? ~str_off_next : 4'h0;
  // Overvoltage and set-resistor short leave the pin released
  assign fault_next = (str_off_next != 4'h0) || scp_next || therm_next;

  lsfd_switch_timer u_timer (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .run_in(switch_ok),
    .period_in(period_in),
    .loop_off_in(loop_off_in),
    .gate_out(gate_raw)
  );

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= LSFD_OFF;
      dim_low_reg <= '0;
      ovp_reg <= 1'b0;
      scp_reg <= 1'b0;
      therm_reg <= 1'b0;
      gate_out <= 1'b0;
      ss_run_out <= 1'b0;
      sink_on_out <= 4'h0;
      fault_oe_out <= 1'b0;
      fault_o_out <= 1'b0;
      state_out <= 3'h0;
    end else if (!en_ok) begin
      state_reg <= LSFD_OFF;
      dim_low_reg <= '0;
      ovp_reg <= 1'b0;
      scp_reg <= 1'b0;
      therm_reg <= 1'b0;
      gate_out <= 1'b0;
      ss_run_out <= 1'b0;
      sink_on_out <= 4'h0;
      fault_oe_out <= 1'b0;
      fault_o_out <= 1'b0;
      state_out <= 3'h0;
    end else begin
      state_reg <= state_next;
      dim_low_reg <= dim_in ? '0 : (dim_timeout ? dim_low_reg : dim_low_reg + 26'd1);
      ovp_reg <= ovp_next;
      scp_reg <= scp_next;
      therm_reg <= therm_next;
      gate_out <= gate_raw && switch_ok;
      ss_run_out <= (state_next == LSFD_SOFT_START);
      sink_on_out <= sink_next;
      fault_oe_out <= fault_next;
      fault_o_out <= 1'b0;
      state_out <= 3'(state_next);
    end
  end
endmodule : lsfd_control

// file: lsfd_control_properties.sv
// Concurrent checks on the controller ports
`timescale 1ns/1ns
module lsfd_control_properties import lsfd_pkg::*; (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic dim_in,
  input wire lsfd_sense_t sense_in,
  input wire lsfd_string_t string_in,
  input wire logic gate_out,
  input wire logic [3:0] sink_on_out,
  input wire logic fault_oe_out,
  input wire logic [2:0] state_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  down_all_off_a: assert property (state_out == 3'h3 |-> sink_on_out == 4'h0 && !gate_out)
    else $error("sink or gate on in shutdown");
  sink_needs_dim_a: assert property (sink_on_out != 4'h0 |-> $past(dim_in))
    else $error("sink on after dimming low");
  ovp_gate_off_a: assert property (sense_in.ovp_rise ##1 sense_in.ovp_rise |=> !gate_out)
    else $error("gate on during overvoltage");
  fault_cause_a: assert property ($rose(fault_oe_out) |->
    $past(string_in != 8'h0 || sense_in.scp_low || sense_in.therm_hot))
    else $error("fault pulled low without cause");
  down_exit_ss_a: assert property (state_out == 3'h3 |=> state_out != 3'h2)
    else $error("shutdown left without soft start");
  ss_no_scp_a: assert property (enable_in && state_out == 3'h1 && dim_in && string_in == 8'h0
    && !sense_in.therm_hot && !sense_in.current_set_resistor_short |=> state_out != 3'h3)
    else $error("shutdown during soft start");
  hot_shutdown_a: assert property (enable_in && state_out == 3'h2 && sense_in.therm_hot
    |=> state_out == 3'h3 && fault_oe_out)
    else $error("no thermal shutdown");
  disabled_idle_a: assert property (!enable_in |=> state_out == 3'h0 && sink_on_out == 4'h0
    && !fault_oe_out && !gate_out)
    else $error("active while disabled");
endmodule : lsfd_control_properties
bind lsfd_control lsfd_control_properties u_props (.clock_in(clock_in), .resetn_in(resetn_in),
  .enable_in(enable_in), .dim_in(dim_in), .sense_in(sense_in), .string_in(string_in),
  .gate_out(gate_out), .sink_on_out(sink_on_out), .fault_oe_out(fault_oe_out),
  .state_out(state_out));

// file: lsfd_string_model.sv
// Dimming host and four LED strings
`timescale 1ns/1ns
module lsfd_string_model import lsfd_pkg::*; (
  input wire logic dim_req_in,
  input wire logic [3:0] open_in,
  input wire logic [3:0] short_in,
  input wire logic [3:0] sink_on_in,
  output logic dim_out,
  output lsfd_string_t string_out
);
  assign dim_out = dim_req_in;
  // A string with its sink off shows no fault voltage
  assign string_out.short_det = short_in & sink_on_in;
  assign string_out.open_det = open_in & sink_on_in;
endmodule : lsfd_string_model

// file: test_lsfd_control.sv
// Self-checking testbench of the controller
`timescale 1ns/1ns
module test_lsfd_control import lsfd_pkg::*;;
  logic clock_in = 1'b0, resetn_in = 1'b0, enable_in = 1'b0, dim_req = 1'b0, dim_in;
  logic loop_off_in = 1'b0, ss_done_in = 1'b0, gate_out, ss_run_out, fault_oe_out, fault_o_out;
  logic [7:0] period_in = 8'h14;
  logic [3:0] open_req = 4'h0, short_req = 4'h0, sink_on_out;
  logic [2:0] state_out;
  lsfd_sense_t sense_in = '0;
  lsfd_string_t string_in;
  int failures = 0, tests_run = 0, rises = 0;
  lsfd_control #(.DIM_LOW_CYC(50)) u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .enable_in(enable_in), .dim_in(dim_in), .period_in(period_in), .loop_off_in(loop_off_in),
    .ss_done_in(ss_done_in), .sense_in(sense_in), .string_in(string_in), .gate_out(gate_out),
    .ss_run_out(ss_run_out), .sink_on_out(sink_on_out), .fault_oe_out(fault_oe_out),
    .fault_o_out(fault_o_out), .state_out(state_out));
  lsfd_string_model u_model (.dim_req_in(dim_req), .open_in(open_req), .short_in(short_req),
    .sink_on_in(sink_on_out), .dim_out(dim_in), .string_out(string_in));
  initial forever #20 clock_in = ~clock_in;
  // Current loop ends each on-time one cycle after the gate rises
  always @(negedge clock_in) loop_off_in <= gate_out;
  always @(posedge gate_out) rises++;
  task check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick
  task wait_state(input logic [2:0] exp, input int bound);
    int i;
    for (i = 0; i < bound && state_out !== exp; i++) tick(1);
    check(8'(state_out), 8'(exp));
    if (state_out !== exp) test_done();
  endtask : wait_state
  task rerun;
    enable_in = 1'b0;
    tick(2);
    enable_in = 1'b1;
    wait_state(3'h2, 6);
  endtask : rerun
  task test_start;
    enable_in = 1'b1;
    dim_req = 1'b1;
    tick(1);
    check(8'(state_out), 8'h1);
    check(8'({ss_run_out, sink_on_out}), 8'h1f);
    tick(20);
    check(8'(state_out), 8'h1);
    ss_done_in = 1'b1;
    wait_state(3'h2, 2);
    rises = 0;
    tick(100);
    check(8'(rises >= 4 && rises <= 6), 8'h1);
    $display("test_start done");
  endtask : test_start
  task test_dim;
    dim_req = 1'b0;
    tick(1);
    check(8'(sink_on_out), 8'h0);
    tick(44);
    check(8'(state_out), 8'h2);
    wait_state(3'h3, 12);
    dim_req = 1'b1;
    tick(1);
    check(8'(state_out), 8'h1);
    wait_state(3'h2, 3);
    $display("test_dim done");
  endtask : test_dim
  task test_string;
    short_req = 4'h2;
    tick(2);
    check(8'({fault_oe_out, sink_on_out}), 8'h1d);
    sense_in.lsd_disable = 1'b1;
    rerun();
    tick(3);
    check(8'({fault_oe_out, sink_on_out}), 8'h0f);
    short_req = 4'h0;
    open_req = 4'h1;
    tick(3);
    check(8'(sink_on_out), 8'hf);
    sense_in.ovp_rise = 1'b1;
    tick(2);
    check(8'({fault_oe_out, sink_on_out}), 8'h1e);
    open_req = 4'hf;
    wait_state(3'h3, 6);
    open_req = 4'h0;
    sense_in = '0;
    $display("test_string done");
  endtask : test_string
  task test_faults;
    rerun();
    sense_in.ovp_rise = 1'b1;
    tick(2);
    rises = 0;
    tick(60);
    check(8'({fault_oe_out, 7'(rises)}), 8'h0);
    sense_in = 8'h40;
    tick(60);
    check(8'(rises > 0), 8'h1);
    sense_in = 8'h48;
    wait_state(3'h3, 3);
    check(8'({fault_o_out, fault_oe_out}), 8'h01);
    sense_in = 8'h44;
    wait_state(3'h2, 6);
    sense_in = 8'h42;
    wait_state(3'h3, 3);
    check(8'(fault_oe_out), 8'h0);
    sense_in = 8'h40;
    wait_state(3'h2, 6);
    sense_in = 8'h20;
    wait_state(3'h3, 3);
    check(8'(fault_oe_out), 8'h1);
    sense_in = 8'h10;
    wait_state(3'h2, 6);
    ss_done_in = 1'b0;
    enable_in = 1'b0;
    tick(2);
    enable_in = 1'b1;
    sense_in = 8'h20;
    wait_state(3'h1, 6);
    tick(5);
    check(8'(state_out), 8'h1);
    sense_in = '0;
    $display("test_faults done");
  endtask : test_faults
  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    tick(12);
    resetn_in = 1'b1;
    tick(1);
    test_start();
    test_dim();
    test_string();
    test_faults();
    test_done();
  end
endmodule : test_lsfd_control
